// ===== hdl/noc_arb_pkg.sv
// constants shared by the output-port arbiter and its route table
// assumes one noc clock domain for all users
package noc_arb_pkg;
  localparam int NUM_IN      = 3;
  localparam int NUM_VC      = 8;
  localparam int NUM_CAND    = NUM_IN * NUM_VC;
  localparam int IN_W        = 2;
  localparam int VC_W        = 3;
  localparam int CAND_W      = 5;
  localparam int PORT_W      = 2;
  localparam int MIN_LATENCY = 2;
  localparam logic [PORT_W-1:0] RT_RST_PORT = 2'h0;

  typedef enum logic [1:0] {
    LNK_RESET,
    LNK_WAIT,
    LNK_RUN
  } link_state_t;
endpackage : noc_arb_pkg

// ===== hdl/noc_route_table.sv
// destination-to-output-port lookup memory, one read port
// assumes writes come from boot-time configuration while traffic is quiet
`timescale 1ns/10ps
module noc_route_table #(
  parameter int DEST_W = 4
) (
  input  wire logic                                 i_core_clk,
  input  wire logic                                 i_rst,
  input  wire logic                                 i_clk_en,
  input  wire logic                                 i_we,
  input  wire logic [DEST_W-1:0]                    i_waddr,
  input  wire logic [noc_arb_pkg::PORT_W-1:0]       i_wdata,
  input  wire logic [DEST_W-1:0]                    i_raddr,
  output logic      [noc_arb_pkg::PORT_W-1:0]       o_rdata
);
  logic [noc_arb_pkg::PORT_W-1:0] mem_q [2**DEST_W];

  always_ff @(posedge i_core_clk) begin
    if (i_clk_en && i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  // read data registered: this is the first cycle through the switch
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= noc_arb_pkg::RT_RST_PORT;
    end else if (i_clk_en) begin
      o_rdata <= mem_q[i_raddr];
    end
  end
endmodule : noc_route_table

// ===== hdl/noc_switch_vc_output_arbiter.sv
// one output port of a packet switch: route lookup, per-vc slots,
// lru arbitration with priority, locks, tokens and credit flow
// assumes upstream sends only with credit and all inputs share i_core_clk
`timescale 1ns/10ps
module noc_switch_vc_output_arbiter #(
  parameter int                                 DATA_W  = 64,
  parameter int                                 DEST_W  = 4,
  parameter int                                 TOK_W   = 4,
  parameter int                                 CRD_W   = 3,
  parameter logic [noc_arb_pkg::PORT_W-1:0]     MY_PORT = 2'h0
) (
  input  wire logic                             i_core_clk,
  input  wire logic                             i_rst,
  input  wire logic                             i_clk_en,
  input  wire logic                             i_rt_we,
  input  wire logic [DEST_W-1:0]                i_rt_addr,
  input  wire logic [noc_arb_pkg::PORT_W-1:0]   i_rt_port,
  input  wire logic [noc_arb_pkg::NUM_CAND*TOK_W-1:0] i_tok_reload,
  input  wire logic [noc_arb_pkg::NUM_IN-1:0]   i_up_rdy,
  input  wire logic [noc_arb_pkg::NUM_IN-1:0]   i_in_valid,
  input  wire logic [noc_arb_pkg::NUM_IN*3-1:0] i_in_vc,
  input  wire logic [noc_arb_pkg::NUM_IN*DEST_W-1:0] i_in_dest,
  input  wire logic [noc_arb_pkg::NUM_IN-1:0]   i_in_last,
  input  wire logic [noc_arb_pkg::NUM_IN-1:0]   i_in_hi,
  input  wire logic [noc_arb_pkg::NUM_IN*DATA_W-1:0] i_in_data,
  input  wire logic                             i_dn_rdy,
  input  wire logic [noc_arb_pkg::NUM_VC-1:0]   i_dn_credit,
  output logic                                  o_link_rdy,
  output logic      [noc_arb_pkg::NUM_CAND-1:0] o_up_credit,
  output logic                                  o_out_valid,
  output logic      [noc_arb_pkg::VC_W-1:0]     o_out_vc,
  output logic      [noc_arb_pkg::IN_W-1:0]     o_out_in,
  output logic                                  o_out_hi,
  output logic                                  o_out_last,
  output logic      [DATA_W-1:0]                o_out_data
);
  localparam int NI = noc_arb_pkg::NUM_IN;
  localparam int NV = noc_arb_pkg::NUM_VC;
  localparam int NC = noc_arb_pkg::NUM_CAND;
  localparam int CW = noc_arb_pkg::CAND_W;

  noc_arb_pkg::link_state_t  link_q, link_d;
  logic [NI-1:0]             init_q, init_d;
  logic [NV-1:0][CRD_W-1:0]  crd_q, crd_d;
  logic [NI-1:0]             st_v_q, st_last_q, st_hi_q;
  logic [NI-1:0][2:0]        st_vc_q;
  logic [NI-1:0][DATA_W-1:0] st_data_q;
  logic [NI-1:0][noc_arb_pkg::PORT_W-1:0] rt_port;
  logic [NC-1:0]             slot_v_q, slot_v_d, slot_last_q, slot_last_d;
  logic [NC-1:0]             slot_hi_q, slot_hi_d;
  logic [NC-1:0][DATA_W-1:0] slot_data_q, slot_data_d;
  logic [NC-1:0][TOK_W-1:0]  tok_q, tok_d;
  logic [NC-1:0][NC-1:0]     older_q, older_d;
  logic [NV-1:0]             lock_v_q, lock_v_d;
  logic [NV-1:0][1:0]        lock_in_q, lock_in_d;
  logic [NC-1:0]             elig, cand, win, up_credit_d;
  logic                      gnt, reload, run;
  logic [CW-1:0]             gidx;
  logic [2:0]                gvc;

  // route lookup, one table copy per input port
  for (genvar i = 0; i < NI; i++) begin : g_rt
    noc_route_table #(.DEST_W(DEST_W)) u_rt (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_clk_en   (i_clk_en),
      .i_we       (i_rt_we),
      .i_waddr    (i_rt_addr),
      .i_wdata    (i_rt_port),
      .i_raddr    (i_in_dest[i*DEST_W +: DEST_W]),
      .o_rdata    (rt_port[i])
    );
  end

  assign run        = (link_q == noc_arb_pkg::LNK_RUN);
  assign o_link_rdy = (link_q != noc_arb_pkg::LNK_RESET);
  assign gvc        = gidx[2:0];

  // link bring-up and downstream credit count
  always_comb begin
    link_d = link_q;
    init_d = init_q;
    unique case (link_q)
      noc_arb_pkg::LNK_RESET: link_d = noc_arb_pkg::LNK_WAIT;
      noc_arb_pkg::LNK_WAIT:  if (i_dn_rdy) link_d = noc_arb_pkg::LNK_RUN;
      noc_arb_pkg::LNK_RUN:   link_d = noc_arb_pkg::LNK_RUN;
    endcase
    for (int v = 0; v < NV; v++) begin
      crd_d[v] = crd_q[v] + CRD_W'(run && i_dn_credit[v])
               - CRD_W'(gnt && (gvc == 3'(v)));
    end
    up_credit_d = win & {NC{gnt}};
    for (int i = 0; i < NI; i++) begin
      if (o_link_rdy && i_up_rdy[i] && !init_q[i]) begin
        init_d[i] = 1'b1;
        up_credit_d[i*NV +: NV] = {NV{1'b1}};
      end
    end
  end

  // eligibility, priority filter and lru pick
  always_comb begin
    gnt  = 1'b0;
    gidx = '0;
    for (int c = 0; c < NC; c++) begin
      elig[c] = slot_v_q[c] && run && (crd_q[c % NV] != '0)
              && (!lock_v_q[c % NV] || lock_in_q[c % NV] == 2'(c / NV))
              && (tok_q[c] != '0);
    end
    cand = (|(elig & slot_hi_q)) ? (elig & slot_hi_q) : elig;
    for (int c = 0; c < NC; c++) begin
      win[c] = cand[c];
      for (int j = 0; j < NC; j++) begin
        if (j != c && cand[j] && !older_q[c][j]) win[c] = 1'b0;
      end
      if (win[c]) begin
        gnt  = 1'b1;
        gidx = CW'(c);
      end
    end
    reload = |(slot_v_q & ~elig_tok_nz()) && !(|(slot_v_q & elig_tok_nz()));
  end

  function automatic logic [NC-1:0] elig_tok_nz();
    logic [NC-1:0] r;
    for (int c = 0; c < NC; c++) r[c] = (tok_q[c] != '0);
    return r;
  endfunction : elig_tok_nz

  // slot, token, lock and lru state updates
  always_comb begin
    slot_v_d    = slot_v_q;
    slot_last_d = slot_last_q;
    slot_hi_d   = slot_hi_q;
    slot_data_d = slot_data_q;
    tok_d       = tok_q;
    older_d     = older_q;
    lock_v_d    = lock_v_q;
    lock_in_d   = lock_in_q;
    if (reload) begin
      tok_d = i_tok_reload;
    end else if (gnt) begin
      tok_d[gidx] = tok_q[gidx] - TOK_W'(1);
    end
    if (gnt) begin
      slot_v_d[gidx]  = 1'b0;
      lock_v_d[gvc]   = !slot_last_q[gidx];
      lock_in_d[gvc]  = gidx[4:3];
      for (int j = 0; j < NC; j++) begin
        older_d[gidx][j] = 1'b0;
        if (j != int'(gidx)) older_d[j][gidx] = 1'b1;
      end
    end
    for (int i = 0; i < NI; i++) begin
      if (st_v_q[i] && rt_port[i] == MY_PORT) begin
        slot_v_d[i*NV + int'(st_vc_q[i])]    = 1'b1;
        slot_last_d[i*NV + int'(st_vc_q[i])] = st_last_q[i];
        slot_hi_d[i*NV + int'(st_vc_q[i])]   = st_hi_q[i];
        slot_data_d[i*NV + int'(st_vc_q[i])] = st_data_q[i];
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      link_q      <= noc_arb_pkg::LNK_RESET;
      init_q      <= '0;
      crd_q       <= '0;
      st_v_q      <= '0;
      st_last_q   <= '0;
      st_hi_q     <= '0;
      st_vc_q     <= '0;
      st_data_q   <= '0;
      slot_v_q    <= '0;
      slot_last_q <= '0;
      slot_hi_q   <= '0;
      slot_data_q <= '0;
      tok_q       <= '0;
      lock_v_q    <= '0;
      lock_in_q   <= '0;
      o_up_credit <= '0;
      o_out_valid <= 1'b0;
      o_out_vc    <= '0;
      o_out_in    <= '0;
      o_out_hi    <= 1'b0;
      o_out_last  <= 1'b0;
      o_out_data  <= '0;
      for (int i = 0; i < NC; i++) begin
        for (int j = 0; j < NC; j++) older_q[i][j] <= (i < j);
      end
    end else if (i_clk_en) begin
      link_q      <= link_d;
      init_q      <= init_d;
      crd_q       <= crd_d;
      // lookup stage carries the flit beside the table read
      st_v_q      <= i_in_valid;
      st_last_q   <= i_in_last;
      st_hi_q     <= i_in_hi;
      st_vc_q     <= i_in_vc;
      st_data_q   <= i_in_data;
      slot_v_q    <= slot_v_d;
      slot_last_q <= slot_last_d;
      slot_hi_q   <= slot_hi_d;
      slot_data_q <= slot_data_d;
      tok_q       <= tok_d;
      older_q     <= older_d;
      lock_v_q    <= lock_v_d;
      lock_in_q   <= lock_in_d;
      o_up_credit <= up_credit_d;
      o_out_valid <= gnt;
      o_out_vc    <= gvc;
      o_out_in    <= gidx[4:3];
      o_out_hi    <= slot_hi_q[gidx];
      o_out_last  <= slot_last_q[gidx];
      o_out_data  <= slot_data_q[gidx];
    end
  end

  // helpers for the checks below
  logic [CW-1:0]    chk_g_q;
  logic [TOK_W-1:0] chk_tok_q;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      chk_g_q   <= '0;
      chk_tok_q <= '0;
    end else if (i_clk_en) begin
      chk_g_q   <= gidx;
      chk_tok_q <= tok_q[gidx];
    end
  end

  sequence s_grant_ok;
    gnt && i_clk_en && !reload;
  endsequence
  sequence s_token_taken;
    tok_q[chk_g_q] == chk_tok_q - TOK_W'(1);
  endsequence

  a_one_grant: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $onehot0(win)) else $error("more than one winner");
  a_grant_credit: assert property (@(posedge i_core_clk) disable iff (i_rst)
    gnt |-> slot_v_q[gidx] && crd_q[gvc] != '0)
    else $error("grant without request or credit");
  a_grant_token: assert property (@(posedge i_core_clk) disable iff (i_rst)
    gnt |-> tok_q[gidx] != '0) else $error("grant with no token");
  a_token_dec: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_grant_ok |=> s_token_taken) else $error("token not decremented");
  a_reload_load: assert property (@(posedge i_core_clk) disable iff (i_rst)
    reload && i_clk_en |=> tok_q == $past(i_tok_reload))
    else $error("reload missed");
  a_tok_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !reload && !gnt |=> $stable(tok_q)) else $error("tokens moved");
  a_prio_first: assert property (@(posedge i_core_clk) disable iff (i_rst)
    gnt && |(elig & slot_hi_q) |-> slot_hi_q[gidx])
    else $error("low priority beat high");
  a_lock_owner: assert property (@(posedge i_core_clk) disable iff (i_rst)
    gnt && lock_v_q[gvc] |-> lock_in_q[gvc] == gidx[4:3])
    else $error("locked vc granted to other input");
  a_lru_update: assert property (@(posedge i_core_clk) disable iff (i_rst)
    gnt && i_clk_en |=> older_q[chk_g_q] == '0)
    else $error("granted pair not most recent");
  a_credit_idle: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !run |-> crd_q == '0) else $error("credit before link up");
  a_out_latency: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_out_valid |-> $past(slot_v_q[gidx]))
    else $error("flit left without buffering");
endmodule : noc_switch_vc_output_arbiter

// ===== verif/dn_switch_model.sv
// downstream switch model: ready level, one initial credit per vc,
// then one credit back per delivered flit, held back while stalled
`timescale 1ns/10ps
module dn_switch_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_link_rdy,
  input  wire logic       i_stall,
  input  wire logic       i_flit_valid,
  input  wire logic [2:0] i_flit_vc,
  output logic            o_dn_rdy,
  output logic      [7:0] o_dn_credit
);
  logic [1:0] phase_q;
  logic [7:0] owed_q;
  logic [7:0] owed_d;
  assign owed_d = owed_q | ({7'h0, i_flit_valid} << i_flit_vc);
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_q     <= 2'h0;
      owed_q      <= 8'h0;
      o_dn_credit <= 8'h0;
      o_dn_rdy    <= 1'b0;
    end else begin
      o_dn_rdy <= 1'b1;
      o_dn_credit <= 8'h0;
      owed_q <= i_stall ? owed_d : 8'h0;
      if (phase_q == 2'h0 && i_link_rdy && o_dn_rdy) begin
        phase_q <= 2'h1;
      end else if (phase_q == 2'h1) begin
        phase_q <= 2'h2;
        o_dn_credit <= 8'hff;
      end else if (!i_stall) begin
        o_dn_credit <= owed_d;
      end
    end
  end
endmodule : dn_switch_model

// ===== verif/tb.sv
// self-checking bench for one output port of the packet switch
// assumes the downstream model above; upstream flits come from here
`timescale 1ns/10ps
module tb;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         rt_we = 1'b0;
  logic [3:0]   rt_addr = 4'h0;
  logic [1:0]   rt_port = 2'h0;
  logic [2:0]   vld = 3'h0;
  logic [8:0]   vc = 9'h0;
  logic [11:0]  dst = 12'h0;
  logic [2:0]   lst = 3'h0;
  logic [2:0]   hi = 3'h0;
  logic [191:0] dat = {64'h3333, 64'h2222, 64'h1111};
  logic         stall = 1'b0;
  logic [95:0]  tok_rl = {24{4'h2}};
  logic         dn_rdy, link_rdy, o_vld, o_hi, o_last;
  logic [7:0]   dn_crd;
  logic [23:0]  up_crd;
  logic [2:0]   o_vc;
  logic [1:0]   o_in;
  logic [63:0]  o_dat;
  int           fail_count = 0;
  int           samples_checked = 0;
  int           n;

  initial forever #4 clk = ~clk;

  noc_switch_vc_output_arbiter dut (
    .i_core_clk(clk), .i_rst(rst), .i_clk_en(1'b1),
    .i_rt_we(rt_we), .i_rt_addr(rt_addr), .i_rt_port(rt_port),
    .i_tok_reload(tok_rl), .i_up_rdy(3'h7), .i_in_valid(vld),
    .i_in_vc(vc), .i_in_dest(dst), .i_in_last(lst), .i_in_hi(hi),
    .i_in_data(dat), .i_dn_rdy(dn_rdy), .i_dn_credit(dn_crd),
    .o_link_rdy(link_rdy), .o_up_credit(up_crd), .o_out_valid(o_vld),
    .o_out_vc(o_vc), .o_out_in(o_in), .o_out_hi(o_hi),
    .o_out_last(o_last), .o_out_data(o_dat));

  dn_switch_model partner (
    .i_core_clk(clk), .i_rst(rst), .i_link_rdy(link_rdy),
    .i_stall(stall), .i_flit_valid(o_vld), .i_flit_vc(o_vc),
    .o_dn_rdy(dn_rdy), .o_dn_credit(dn_crd));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic rt_wr(input logic [3:0] a, input logic [1:0] p);
    @(posedge clk);
    rt_we <= 1'b1;
    rt_addr <= a;
    rt_port <= p;
    @(posedge clk);
    rt_we <= 1'b0;
  endtask : rt_wr

  // one flit per input in mask m, all taken at the same edge
  task automatic send(input logic [2:0] m, input logic [8:0] v,
                      input logic [11:0] d, input logic [2:0] l,
                      input logic [2:0] h);
    @(posedge clk);
    vld <= m;
    vc <= v;
    dst <= d;
    lst <= l;
    hi <= h;
    @(posedge clk);
    vld <= 3'h0;
  endtask : send

  // cycles until the next flit leaves, 40 if none
  task automatic get(output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (o_vld !== 1'b1 && k < 40);
  endtask : get

  task automatic expf(input logic [1:0] i, input logic [2:0] v);
    int k;
    get(k);
    check(64'(o_vld), 64'h1);
    check(64'(o_in), 64'(i));
    check(64'(o_vc), 64'(v));
    check(o_dat, 64'h1111 * (i + 64'h1));
    check(64'(up_crd), 64'h1 << (i * 8 + v));
  endtask : expf

  task automatic t_link;
    @(posedge clk);
    #1;
    check(64'(link_rdy), 64'h0);
    @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 10 && up_crd === 24'h0; k++) begin
      @(posedge clk);
      #1;
    end
    check(64'(up_crd), 64'hffffff);
  endtask : t_link

  task automatic t_route;
    rt_wr(4'h1, 2'h0);
    rt_wr(4'h2, 2'h1);
    send(3'h2, 9'h0, 12'h020, 3'h7, 3'h0);
    get(n);
    check(64'(n), 64'h28);
    send(3'h2, 9'h0, 12'h010, 3'h7, 3'h0);
    get(n);
    check(64'(n), 64'h3);
    check(64'(o_in), 64'h1);
  endtask : t_route

  task automatic t_arb;
    send(3'h3, {3'h0, 3'h5, 3'h4}, 12'h111, 3'h7, 3'h2);
    expf(2'h1, 3'h5);
    check(64'(o_hi), 64'h1);
    expf(2'h0, 3'h4);
    check(64'(o_hi), 64'h0);
    send(3'h1, {3'h0, 3'h0, 3'h6}, 12'h111, 3'h7, 3'h0);
    expf(2'h0, 3'h6);
    send(3'h5, {3'h6, 3'h0, 3'h6}, 12'h111, 3'h7, 3'h0);
    expf(2'h2, 3'h6);
    expf(2'h0, 3'h6);
  endtask : t_arb

  task automatic t_lock;
    @(posedge clk);
    tok_rl <= {24{4'h3}};
    send(3'h3, {3'h0, 3'h2, 3'h2}, 12'h111, 3'h2, 3'h0);
    expf(2'h0, 3'h2);
    check(64'(o_last), 64'h0);
    get(n);
    check(64'(n), 64'h28);
    send(3'h1, {3'h0, 3'h0, 3'h2}, 12'h111, 3'h7, 3'h0);
    expf(2'h0, 3'h2);
    expf(2'h1, 3'h2);
  endtask : t_lock

  task automatic t_credit;
    @(posedge clk);
    stall <= 1'b1;
    send(3'h1, {3'h0, 3'h0, 3'h3}, 12'h111, 3'h7, 3'h0);
    expf(2'h0, 3'h3);
    send(3'h1, {3'h0, 3'h0, 3'h3}, 12'h111, 3'h7, 3'h0);
    get(n);
    check(64'(n), 64'h28);
    @(posedge clk);
    stall <= 1'b0;
    expf(2'h0, 3'h3);
  endtask : t_credit

  initial begin
    t_link;
    $display("link test done");
    t_route;
    $display("route test done");
    t_arb;
    $display("arbitration test done");
    t_lock;
    $display("lock test done");
    t_credit;
    $display("credit test done");
    tally_and_finish;
  end

  initial begin
    #20000;
    fail_count++;
    tally_and_finish;
  end
endmodule : tb
